/* File: include/storage_cluster_pkg.sv */
// constants for the four-element configurable storage cluster
package storage_cluster_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] ELEM_OFS = 8'h04;
	localparam logic [7:0] OSEL_OFS = 8'h08;
	localparam logic [7:0] STAT_OFS = 8'h0C;
	// control register fields
	localparam int CTRL_CLK_INV = 0;
	localparam int CTRL_CE_INV = 1;
	localparam int CTRL_LSR_INV = 2;
	localparam int CTRL_MODE_LO = 3;
	localparam int CTRL_PRIO = 5;
	localparam int CTRL_SRC_DIRECT = 6;
	localparam int CTRL_PAD_EN = 7;
	localparam int CTRL_W = 8;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// local set/reset modes
	localparam logic [1:0] MODE_SYNC = 2'h0;
	localparam logic [1:0] MODE_ASYNC = 2'h1;
	localparam logic [1:0] MODE_FESEL = 2'h2;
	// element register fields
	localparam int ELEM_LATCH_LO = 0;
	localparam int ELEM_SETVAL_LO = 4;
	localparam int ELEM_DSEL_LO = 8;
	localparam int ELEM_W = 16;
	localparam logic [15:0] ELEM_RST = 16'h0000;
	// per-element data input choices
	localparam logic [1:0] DSEL_ZERO = 2'h0;
	localparam logic [1:0] DSEL_CELL = 2'h1;
	localparam logic [1:0] DSEL_PAD_LR = 2'h2;
	localparam logic [1:0] DSEL_PAD_TB = 2'h3;
	// output selector: three bits per general output
	localparam int OSEL_FIELD = 3;
	localparam int OSEL_W = 15;
	localparam logic [14:0] OSEL_RST = 15'h0000;
	// input synchroniser vector layout
	localparam int SYN_CLK = 0;
	localparam int SYN_CE = 1;
	localparam int SYN_LSR = 2;
	localparam int SYN_GSR_N = 3;
	localparam int SYN_LUT_LO = 4;
	localparam int SYN_DIR_LO = 8;
	localparam int SYN_LR_LO = 12;
	localparam int SYN_TB_LO = 16;
	localparam int SYN_W = 20;
	localparam logic [19:0] SYN_RST = 20'h00008;
endpackage

/* File: verilog/storage_cluster.sv */
// four latch/flip-flop storage cluster with APB configuration
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
module storage_cluster #(
	parameter bit HAS_LR_PAD = 1'b0,
	parameter bit HAS_TB_PAD = 1'b0,
	parameter bit IO_ADJACENT = 1'b0
) (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// cell-side inputs, asynchronous to pclk
	input wire logic cell_clk,
	input wire logic clock_enable,
	input wire logic local_set_reset,
	input wire logic global_set_reset_n,
	input wire logic [3:0] lut_out,
	input wire logic [3:0] direct_data_in,
	input wire logic [3:0] pad_lr_in,
	input wire logic [3:0] pad_tb_in,
	// element outputs
	output logic [3:0] elem_q,
	output logic [4:0] cell_out,
	output logic [3:0] io_pad_out,
	output logic io_pad_out_en
);
	// picks an element's data from its configured source
	function automatic logic pick_data(
		input logic [1:0] dsel,
		input logic cell_bit,
		input logic lr_bit,
		input logic tb_bit
	);
		logic r;
		r = 1'b0;
		unique case (dsel)
			storage_cluster_pkg::DSEL_ZERO: r = 1'b0;
			storage_cluster_pkg::DSEL_CELL: r = cell_bit;
			storage_cluster_pkg::DSEL_PAD_LR: r = lr_bit & HAS_LR_PAD;
			storage_cluster_pkg::DSEL_PAD_TB: r = tb_bit & HAS_TB_PAD;
		endcase
		return r;
	endfunction

	// selects one element output for a general output
	function automatic logic pick_out(
		input logic [2:0] sel,
		input logic [3:0] q
	);
		logic r;
		r = 1'b0;
		if (sel[2] == 1'b0) begin
			r = q[sel[1:0]];
		end
		return r;
	endfunction

	logic [19:0] syn1_reg;
	logic [19:0] syn2_reg;
	logic [7:0] ctrl_reg;
	logic [15:0] elem_reg;
	logic [14:0] osel_reg;
	logic clk_prev_reg;
	logic [3:0] q_reg;
	logic [3:0] q_next;
	logic [4:0] out_reg;
	logic [4:0] out_next;
	logic [3:0] pad_reg;
	logic pad_en_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic err_reg;

	// two-stage synchroniser on every cell-side input
	wire logic [19:0] syn_raw = {pad_tb_in, pad_lr_in, direct_data_in,
		lut_out, global_set_reset_n, local_set_reset, clock_enable,
		cell_clk};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			syn1_reg <= storage_cluster_pkg::SYN_RST;
			syn2_reg <= storage_cluster_pkg::SYN_RST;
		end else begin
			syn1_reg <= syn_raw;
			syn2_reg <= syn1_reg;
		end
	end

	// configuration fields
	wire logic clk_inv = ctrl_reg[storage_cluster_pkg::CTRL_CLK_INV];
	wire logic ce_inv = ctrl_reg[storage_cluster_pkg::CTRL_CE_INV];
	wire logic lsr_inv = ctrl_reg[storage_cluster_pkg::CTRL_LSR_INV];
	wire logic [1:0] lsr_mode =
		ctrl_reg[storage_cluster_pkg::CTRL_MODE_LO +: 2];
	wire logic lsr_prio = ctrl_reg[storage_cluster_pkg::CTRL_PRIO];
	wire logic src_direct = ctrl_reg[storage_cluster_pkg::CTRL_SRC_DIRECT];
	wire logic pad_en = ctrl_reg[storage_cluster_pkg::CTRL_PAD_EN];
	wire logic [3:0] is_latch =
		elem_reg[storage_cluster_pkg::ELEM_LATCH_LO +: 4];
	wire logic [3:0] set_val =
		elem_reg[storage_cluster_pkg::ELEM_SETVAL_LO +: 4];

	// synchronised cell inputs
	wire logic clk_s = syn2_reg[storage_cluster_pkg::SYN_CLK];
	wire logic ce_s = syn2_reg[storage_cluster_pkg::SYN_CE];
	wire logic lsr_s = syn2_reg[storage_cluster_pkg::SYN_LSR];
	wire logic gsr_n_s = syn2_reg[storage_cluster_pkg::SYN_GSR_N];
	wire logic [3:0] lut_s = syn2_reg[storage_cluster_pkg::SYN_LUT_LO +: 4];
	wire logic [3:0] dir_s = syn2_reg[storage_cluster_pkg::SYN_DIR_LO +: 4];
	wire logic [3:0] lr_s = syn2_reg[storage_cluster_pkg::SYN_LR_LO +: 4];
	wire logic [3:0] tb_s = syn2_reg[storage_cluster_pkg::SYN_TB_LO +: 4];

	// shared clock with optional inversion, and its active edge
	wire logic clk_eff = clk_s ^ clk_inv;
	wire logic clk_edge = clk_eff & ~clk_prev_reg;
	wire logic latch_open = clk_eff;

	// polarity of enable and local set/reset
	wire logic ce_act = ce_s ^ ce_inv;
	wire logic lsr_act = lsr_s ^ lsr_inv;

	// mode decode; the unused code behaves as synchronous
	wire logic mode_async = (lsr_mode == storage_cluster_pkg::MODE_ASYNC);
	wire logic mode_fesel = (lsr_mode == storage_cluster_pkg::MODE_FESEL);
	wire logic mode_sync = !mode_async && !mode_fesel;

	// global and asynchronous local forcing
	wire logic gsr_force = !gsr_n_s;
	wire logic async_force = mode_async && lsr_act;

	// synchronous local set/reset; flip-flops gated by enable unless prioritised, latches ungated
	wire logic sync_sr_ff = mode_sync && lsr_act &&
		(ce_act || lsr_prio);
	wire logic sync_sr_latch = mode_sync && lsr_act;

	// cell-wide source, overridden per cycle in front-end select mode
	wire logic use_direct = mode_fesel ? lsr_act : src_direct;
	wire logic [3:0] cell_src = use_direct ? dir_s : lut_s;

	// per-element next state
	always_comb begin
		q_next = q_reg;
		for (int i = 0; i < 4; i++) begin
			logic d;
			d = pick_data(elem_reg[storage_cluster_pkg::ELEM_DSEL_LO + 2*i
				+: 2], cell_src[i], lr_s[i], tb_s[i]);
			if (gsr_force) begin
				q_next[i] = set_val[i];
			end else if (async_force) begin
				q_next[i] = set_val[i];
			end else if (is_latch[i]) begin
				if (latch_open) begin
					q_next[i] = sync_sr_latch ? set_val[i] : d;
				end
			end else if (clk_edge) begin
				if (sync_sr_ff) begin
					q_next[i] = set_val[i];
				end else if (ce_act) begin
					q_next[i] = d;
				end else begin
					q_next[i] = q_reg[i];
				end
			end
		end
	end

	// general output selection from the new element state
	always_comb begin
		for (int j = 0; j < 5; j++) begin
			out_next[j] = pick_out(
				osel_reg[storage_cluster_pkg::OSEL_FIELD*j +: 3],
				q_next);
		end
	end

	// element, output and pad-path registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_prev_reg <= 1'b0;
			q_reg <= 4'h0;
			out_reg <= 5'h00;
			pad_reg <= 4'h0;
			pad_en_reg <= 1'b0;
		end else begin
			clk_prev_reg <= clk_eff;
			q_reg <= q_next;
			out_reg <= out_next;
			pad_reg <= q_next;
			pad_en_reg <= pad_en & IO_ADJACENT;
		end
	end

	assign elem_q = q_reg;
	assign cell_out = out_reg;
	assign io_pad_out = pad_reg;
	assign io_pad_out_en = pad_en_reg;

	// apb decode; answer is ready in the access phase
	wire logic setup = psel && !penable;
	wire logic access = psel && penable;
	wire logic hit_ctrl = (paddr == storage_cluster_pkg::CTRL_OFS);
	wire logic hit_elem = (paddr == storage_cluster_pkg::ELEM_OFS);
	wire logic hit_osel = (paddr == storage_cluster_pkg::OSEL_OFS);
	wire logic hit_stat = (paddr == storage_cluster_pkg::STAT_OFS);
	wire logic hit_any = hit_ctrl || hit_elem || hit_osel || hit_stat;
	wire logic wr_ok = access && pwrite;
	wire logic [31:0] stat_word = {24'h000000, gsr_n_s, lsr_s, ce_s,
		clk_s, q_reg};

	// read data captured during setup
	always_comb begin
		rdata_next = 32'h00000000;
		if (hit_ctrl) begin
			rdata_next = {24'h000000, ctrl_reg};
		end else if (hit_elem) begin
			rdata_next = {16'h0000, elem_reg};
		end else if (hit_osel) begin
			rdata_next = {17'h00000, osel_reg};
		end else if (hit_stat) begin
			rdata_next = stat_word;
		end
	end

	// bus response registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= 32'h00000000;
			err_reg <= 1'b0;
		end else if (setup) begin
			rdata_reg <= pwrite ? 32'h00000000 : rdata_next;
			err_reg <= !hit_any || (pwrite && hit_stat);
		end
	end

	// configuration writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= storage_cluster_pkg::CTRL_RST;
			elem_reg <= storage_cluster_pkg::ELEM_RST;
			osel_reg <= storage_cluster_pkg::OSEL_RST;
		end else if (wr_ok) begin
			if (hit_ctrl) begin
				ctrl_reg <= pwdata[7:0];
			end
			if (hit_elem) begin
				elem_reg <= pwdata[15:0];
			end
			if (hit_osel) begin
				osel_reg <= pwdata[14:0];
			end
		end
	end

	assign pready = 1'b1;
	assign prdata = rdata_reg;
	assign pslverr = access && err_reg;
endmodule

/* File: dv/cell_fabric_model.sv */
// cell fabric model: shared cell clock and lookup outputs
`timescale 1ns/1ns
module cell_fabric_model (
	// timing
	input wire logic pclk,
	input wire logic run,
	// towards the cluster
	output logic cell_clk,
	output logic [3:0] lut_out
);
	int left;
	// each clock level lasts 2..5 pclk, clock rests low outside a run
	always @(posedge pclk) begin
		if (left > 0) begin
			left <= left - 1;
		end else if (run || cell_clk) begin
			cell_clk <= !cell_clk;
			left <= 1 + $urandom % 4;
			lut_out <= 4'($urandom);
		end
	end
	// quiet start
	initial begin
		cell_clk = 1'b0;
		lut_out = 4'h0;
		left = 0;
	end
endmodule

/* File: dv/storage_cluster_sva.sv */
// port assertions for the storage cluster
`timescale 1ns/1ns
module storage_cluster_sva (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// cell side
	input wire logic global_set_reset_n,
	input wire logic [3:0] elem_q,
	input wire logic [4:0] cell_out,
	input wire logic [3:0] io_pad_out,
	input wire logic io_pad_out_en
);
	wire acc;
	wire ctrl_wr;
	// decoded access phase
	assign acc = psel && penable;
	assign ctrl_wr = acc && pwrite && paddr == 8'h00;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	ready_always_a: assert property (pready)
		else $error("pready low");
	err_access_a: assert property (pslverr |-> acc)
		else $error("error outside access");
	bad_addr_a: assert property (acc && paddr > 8'h0C |->
		pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	status_ro_a: assert property (acc && pwrite && paddr == 8'h0C |-> pslverr)
		else $error("status write accepted");
	good_addr_a: assert property (acc && paddr inside {8'h00, 8'h04, 8'h08}
		|-> !pslverr) else $error("mapped access refused");
	rdata_hold_a: assert property (!psel |=> $stable(prdata))
		else $error("read data moved while idle");
	pad_copy_a: assert property (io_pad_out == elem_q)
		else $error("pad path differs");
	pad_en_cause_a: assert property ($changed(io_pad_out_en) |->
		$past(ctrl_wr) || $past(ctrl_wr, 2)) else $error("pad enable moved");
	gsr_hold_a: assert property ((!global_set_reset_n && !psel)[*5] |=>
		$stable(elem_q) && $stable(cell_out)) else $error("state moved");
endmodule
bind storage_cluster storage_cluster_sva i_storage_cluster_sva (.*);

/* File: dv/test_storage_cluster.sv */
// self-checking bench for the storage cluster
`timescale 1ns/1ns
`define CHK(got, exp) begin \
	samples_checked++; \
	if ((got) !== (exp)) begin \
		err_count++; \
		$display("unexpected at %0t: got %h want %h", $time, got, exp); \
	end \
end
module test_storage_cluster;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, run;
	logic [7:0] paddr, m_ctrl;
	logic [31:0] pwdata, prdata, rd, w;
	logic cell_clk, clock_enable, local_set_reset, global_set_reset_n;
	logic [3:0] lut_out, direct_data_in, pad_lr_in, pad_tb_in;
	logic [3:0] elem_q, io_pad_out, m_q;
	logic [4:0] cell_out, eo;
	logic io_pad_out_en, m_prev, ek, ce_a, ls, syl, fs, rise, pri, d, n, sv;
	logic [19:0] s1, s2;
	logic [15:0] m_elem;
	logic m_pen;
	logic [3:0] nq;
	logic [14:0] m_osel;
	logic [1:0] md;
	logic [2:0] f;
	logic [31:0] mk [3] = '{32'hFF, 32'hFFFF, 32'h7FFF};
	int err_count = 0;
	int samples_checked = 0;
	storage_cluster #(.HAS_LR_PAD(1'b1), .HAS_TB_PAD(1'b0), .IO_ADJACENT(1'b1))
		i_storage_cluster (.*);
	cell_fabric_model i_cell_fabric_model (.*);
	// clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// verdict and end of run
	task automatic end_sim;
		if (err_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// one apb transfer, result in rd and er
	task automatic acc(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) begin
			err_count++;
			end_sim;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// reference model: two-stage sampling, then element update per pclk
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{s1, s2, m_prev, m_q} <= {20'h00008, 20'h00008, 5'h00};
			{m_ctrl, m_elem, m_osel} <= '0;
			{eo, m_pen} <= '0;
		end else begin
			s1 <= {pad_tb_in, pad_lr_in, direct_data_in, lut_out,
				global_set_reset_n, local_set_reset, clock_enable, cell_clk};
			s2 <= s1;
			ek = s2[0] ^ m_ctrl[0];
			ce_a = s2[1] ^ m_ctrl[1];
			ls = s2[2] ^ m_ctrl[2];
			md = m_ctrl[4:3];
			syl = ls && (md == 2'h0 || md == 2'h3);
			fs = md == 2'h2 ? ls : m_ctrl[6];
			rise = ek && !m_prev;
			pri = ce_a || m_ctrl[5];
			for (int i = 0; i < 4; i++) begin
				sv = m_elem[4 + i];
				case (m_elem[8 + 2 * i +: 2])
					2'h1: d = s2[fs ? 8 + i : 4 + i];
					2'h2: d = s2[12 + i];
					default: d = 1'b0;
				endcase
				n = m_q[i];
				if (!s2[3] || (md == 2'h1 && ls)) n = sv;
				else if (m_elem[i]) n = ek ? (syl ? sv : d) : n;
				else if (rise && syl && pri) n = sv;
				else if (rise && ce_a) n = d;
				m_q[i] <= n;
				nq[i] = n;
			end
			if (psel && penable && pwrite) begin
				case (paddr)
					8'h00: m_ctrl <= pwdata[7:0];
					8'h04: m_elem <= pwdata[15:0];
					8'h08: m_osel <= pwdata[14:0];
					default: ;
				endcase
			end
			// general outputs follow the new state through the old selector
			for (int j = 0; j < 5; j++) begin
				f = m_osel[3 * j +: 3];
				eo[j] <= f[2] ? 1'b0 : nq[f[1:0]];
			end
			// pad enable is registered one cycle behind the control word
			m_pen <= m_ctrl[7];
			m_prev <= ek;
		end
	end
	// compare with the model every cycle
	always @(negedge pclk) begin
		`CHK(elem_q, m_q)
		`CHK(io_pad_out, m_q)
		`CHK(cell_out, eo)
		`CHK(io_pad_out_en, m_pen)
	end
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, run} = '0;
		{clock_enable, local_set_reset, direct_data_in} = '0;
		{pad_lr_in, pad_tb_in} = '0;
		global_set_reset_n = 1'b1;
		w = $urandom(40587);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		// reset values and refused accesses
		for (int a = 0; a < 20; a += 4) begin
			acc(1'b0, 8'(a), 32'h0);
			`CHK(rd, a == 12 ? 32'h80 : 32'h0)
			`CHK(er, a == 16)
		end
		acc(1'b1, 8'h0C, 32'hFFFFFFFF);
		`CHK(er, 1'b1)
		// every mode with random configuration and traffic
		for (int it = 0; it < 24; it++) begin
			global_set_reset_n <= 1'b0;
			for (int r = 0; r < 3; r++) begin
				w = $urandom;
				if (r == 0) w[4:3] = it[1:0];
				acc(1'b1, 8'(4 * r), w);
				acc(1'b0, 8'(4 * r), 32'h0);
				`CHK(rd, w & mk[r])
			end
			repeat (6) @(posedge pclk);
			global_set_reset_n <= 1'b1;
			run <= 1'b1;
			repeat (80) begin
				@(posedge pclk);
				{clock_enable, local_set_reset, direct_data_in, pad_lr_in,
					pad_tb_in} <= 14'($urandom);
				global_set_reset_n <= ($urandom % 40) != 0;
			end
			run <= 1'b0;
			repeat (8) @(posedge pclk);
		end
		// reset after the last run clears the configuration
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		acc(1'b0, 8'h00, 32'h0);
		`CHK(rd, 32'h0)
		end_sim;
	end
endmodule
